// ---- sar_pkg.sv ----
// Purpose: shared constants for the conversion sequencer
// Assumes: 100 MHz system clock
// Notes: configuration field positions follow the input configuration bits
package sar_pkg;
	localparam int RESULT_W = 16;
	localparam int CONFIG_W = 14;
	localparam int STEPS = 16;
	localparam int CLK_MHZ = 100;
	// sample period at the highest rate, in ns
	localparam int SAMPLE_PERIOD_NS = 2000;
	localparam int SAMPLE_PERIOD_CYC = (SAMPLE_PERIOD_NS * CLK_MHZ) / 1000;
	// switch opening settle time before the arrays are grounded
	localparam int SWITCH_SETTLE_NS = 20;
	localparam int SWITCH_SETTLE_CYC = (SWITCH_SETTLE_NS * CLK_MHZ + 999) / 1000;
	// one bit decision per this many ns
	localparam int BIT_TIME_NS = 50;
	localparam int BIT_TIME_CYC = (BIT_TIME_NS * CLK_MHZ) / 1000;
	// input configuration field, bits 12:10
	localparam int INCC_HI = 12;
	localparam int INCC_LO = 10;
	// top bit of the field set means a unipolar range
	localparam int UNIPOLAR_BIT = 12;
	localparam logic [13:0] CONFIG_RESET = 14'h3_C7F;
	localparam logic [15:0] CODE_MAX_UNI = 16'hFFFF;
	localparam logic [15:0] CODE_MAX_BIP = 16'h7FFF;
	localparam logic [15:0] CODE_MIN_UNI = 16'h0000;
	localparam logic [15:0] CODE_MIN_BIP = 16'h8000;
	localparam logic [15:0] MSB_WEIGHT = 16'h8000;
endpackage : sar_pkg

// ---- sync_fifo.sv ----
// Purpose: small synchronous FIFO between conversion and serial side
// Assumes: one clock, synchronous active-high reset
// Notes: full and empty are exact
`timescale 1ns/10ps
module sync_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = count != (AW+1)'(DEPTH);
	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule : sync_fifo

// ---- serial_port.sv ----
// Purpose: serial shift logic on the host's shift clock
// Assumes: shift clock idles low, data changes on falling, sampled on rising
// Notes: frame is framed by the start input being low
`timescale 1ns/10ps
module serial_port (
	input wire logic sck_i,
	input wire logic frame_n_i,
	input wire logic [29:0] load_word_i,
	input wire logic load_toggle_i,
	input wire logic din_i,
	output logic sdo_o,
	output logic [13:0] config_word_o,
	output logic config_toggle_o,
	output logic load_taken_o
);
	// no reset in this domain: registers start from their declared values
	logic [29:0] shreg = '0;
	logic [29:0] held_word = '0;
	logic [4:0] bitcnt = '0;
	logic [13:0] inreg = '0;
	logic [13:0] cfg_word = sar_pkg::CONFIG_RESET;
	logic cfg_toggle = 1'b0;
	logic seen_toggle = 1'b0;
	wire frame_first = bitcnt == 5'h00;
	wire cfg_last = bitcnt == 5'h0D;

	// start high ends a frame at once, with the shift clock stopped
	// thirty bits make a frame; a longer burst starts the next word
	always_ff @(posedge sck_i or posedge frame_n_i)
	begin
		if (frame_n_i)
			bitcnt <= '0;
		else if (bitcnt == 5'h1D)
			bitcnt <= '0;
		else
			bitcnt <= bitcnt + 5'h01;
	end

	// config bits msb first; completed word passed as a toggle event
	always_ff @(posedge sck_i)
	begin
		if (frame_first)
		begin
			// word and toggle taken on one edge so the echo always matches
			held_word <= load_word_i;
			seen_toggle <= load_toggle_i;
		end
		if (!frame_n_i && bitcnt < 5'h0E)
			inreg <= {inreg[12:0], din_i};
		if (!frame_n_i && cfg_last)
		begin
			cfg_word <= {inreg[12:0], din_i};
			cfg_toggle <= !cfg_toggle;
		end
	end

	// shift out msb first on each falling shift clock edge
	always_ff @(negedge sck_i)
	begin
		if (bitcnt == 5'h01)
			shreg <= {held_word[28:0], 1'b0};
		else
			shreg <= {shreg[28:0], 1'b0};
	end

	assign sdo_o = frame_first ? load_word_i[29] : shreg[29];
	assign config_word_o = cfg_word;
	assign config_toggle_o = cfg_toggle;
	assign load_taken_o = seen_toggle;
endmodule : serial_port

// ---- sar_conversion_sequencer.sv ----
// Contract
// - start rising edge ends acquisition, begins conversion
// - open sampling switches before grounding arrays
// - sixteen halving trial steps, msb first
// - after last bit: acquire, code, busy
// - bit timing from internal clock, not shift clock
// - unipolar ranges give straight binary
// - bipolar ranges give twos complement
// - overrange saturates to top code
// - underrange saturates to bottom code
// - fourteen bit configuration written serially
// - result readable after or during next conversion
// - result belongs to its own conversion
// - sustain 500 kSPS, power down when idle
// - start held low enables busy indication
// - shift clock moves bits msb first
// - configuration writes accepted any time
//
// Purpose: successive approximation control with serial result port
// Assumes: comparator answer stable within one bit time
// Notes: serial side runs on its own clock, crossings are toggles
`timescale 1ns/10ps
module sar_conversion_sequencer #(
	parameter int BIT_CYC = sar_pkg::BIT_TIME_CYC,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic conversion_start_input_i,
	input wire logic comparator_high_i,
	input wire logic over_range_i,
	input wire logic under_range_i,
	input wire logic serial_shift_clock_i,
	input wire logic serial_config_input_i,
	output logic serial_result_output_o,
	output logic positive_sampling_switch_o,
	output logic negative_sampling_switch_o,
	output logic arrays_grounded_o,
	output logic [15:0] trial_code_o,
	output logic converter_powered_o,
	output logic busy_o
);
	typedef enum {ST_ACQUIRE, ST_OPEN, ST_GROUND, ST_TRIAL, ST_DONE} state_t;
	state_t state;
	state_t next_state;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic start_s1;
	logic start_s2;
	logic start_s3;
	logic cfg_t1;
	logic cfg_t2;
	logic cfg_t3;
	logic [13:0] cfg_word;
	logic cfg_toggle;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
			start_s3 <= 1'b0;
			cfg_t1 <= 1'b0;
			cfg_t2 <= 1'b0;
			cfg_t3 <= 1'b0;
		end
		else
		begin
			start_s1 <= conversion_start_input_i;
			start_s2 <= start_s1;
			start_s3 <= start_s2;
			cfg_t1 <= cfg_toggle;
			cfg_t2 <= cfg_t1;
			cfg_t3 <= cfg_t2;
		end
	end
	wire start_rise = start_s2 && !start_s3;
	wire cfg_event = cfg_t2 != cfg_t3;

	// ----------------------------------------
	// configuration register
	// ----------------------------------------
	logic [13:0] config_reg;
	logic [13:0] active_cfg;
	// config word is stable for many serial edges after its toggle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			config_reg <= sar_pkg::CONFIG_RESET;
		else if (cfg_event)
			config_reg <= cfg_word;
	end
	wire unipolar = active_cfg[sar_pkg::UNIPOLAR_BIT];

	// ----------------------------------------
	// approximation engine
	// ----------------------------------------
	logic [15:0] sar;
	logic [15:0] weight;
	logic [7:0] tick;
	logic [4:0] step;
	logic over_seen;
	logic under_seen;
	wire tick_done = tick == 8'(BIT_CYC - 1);
	wire settle_done = tick == 8'(sar_pkg::SWITCH_SETTLE_CYC - 1);

	function automatic logic [15:0] format_code(input logic [15:0] raw, input logic uni,
		input logic ovr, input logic und);
		logic [15:0] code;
		code = ovr ? sar_pkg::CODE_MAX_UNI : (und ? sar_pkg::CODE_MIN_UNI : raw);
		format_code = uni ? code : {!code[15], code[14:0]};
	endfunction : format_code

	always_comb
	begin
		next_state = state;
		case (state)
			ST_ACQUIRE:
				if (start_rise)
					next_state = ST_OPEN;
			ST_OPEN:
				if (settle_done)
					next_state = ST_GROUND;
			ST_GROUND:
				if (settle_done)
					next_state = ST_TRIAL;
			ST_TRIAL:
				if (tick_done && step == 5'(sar_pkg::STEPS - 1))
					next_state = ST_DONE;
			ST_DONE:
				next_state = ST_ACQUIRE;
			default:
				next_state = ST_ACQUIRE;
		endcase
	end

	wire phase_end = (state != next_state) || (state == ST_TRIAL && tick_done);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= ST_ACQUIRE;
		else
			state <= next_state;
	end

	// bit decisions counted on clk_i alone
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state == ST_ACQUIRE || phase_end)
			tick <= '0;
		else
			tick <= tick + 8'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sar <= '0;
			weight <= '0;
			step <= '0;
			active_cfg <= sar_pkg::CONFIG_RESET;
			over_seen <= 1'b0;
			under_seen <= 1'b0;
		end
		else if (state == ST_ACQUIRE && start_rise)
		begin
			// config written during this conversion applies to the next one
			active_cfg <= config_reg;
			sar <= sar_pkg::MSB_WEIGHT;
			weight <= sar_pkg::MSB_WEIGHT;
			step <= '0;
			over_seen <= 1'b0;
			under_seen <= 1'b0;
		end
		else if (state == ST_GROUND && settle_done)
		begin
			over_seen <= over_range_i;
			under_seen <= under_range_i;
		end
		else if (state == ST_TRIAL && tick_done)
		begin
			// keep trial bit if below input, then try next halved weight
			sar <= (comparator_high_i ? sar : sar & ~weight) | (weight >> 1);
			weight <= weight >> 1;
			step <= step + 5'h01;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			positive_sampling_switch_o <= 1'b1;
			negative_sampling_switch_o <= 1'b1;
			arrays_grounded_o <= 1'b0;
			trial_code_o <= '0;
			converter_powered_o <= 1'b0;
		end
		else
		begin
			positive_sampling_switch_o <= next_state == ST_ACQUIRE;
			negative_sampling_switch_o <= next_state == ST_ACQUIRE;
			arrays_grounded_o <= next_state == ST_GROUND || next_state == ST_TRIAL;
			trial_code_o <= sar;
			converter_powered_o <= next_state != ST_ACQUIRE;
		end
	end

	// busy drives low at result ready only while start held low
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			busy_o <= 1'b0;
		else if (state == ST_DONE)
			busy_o <= start_s2;
		else if (start_rise)
			busy_o <= 1'b1;
	end

	// ----------------------------------------
	// result path
	// ----------------------------------------
	logic [29:0] push_word;
	logic push_valid;
	logic fifo_ready;
	logic [29:0] head_word;
	logic head_valid;
	logic [29:0] load_word;
	logic load_toggle;
	logic ack_1;
	logic ack_2;
	logic load_taken;
	logic waiting;
	wire [15:0] final_code = format_code(sar, unipolar, over_seen, under_seen);
	wire fifo_pop = head_valid && !waiting;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			push_valid <= 1'b0;
			push_word <= '0;
		end
		else if (state == ST_DONE)
		begin
			push_valid <= 1'b1;
			push_word <= {final_code, active_cfg};
		end
		else if (fifo_ready)
			push_valid <= 1'b0;
	end

	sync_fifo #(
		.WIDTH(30),
		.DEPTH(FIFO_DEPTH)
	) result_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_data_i(push_word),
		.in_valid_i(push_valid),
		.in_ready_o(fifo_ready),
		.out_data_o(head_word),
		.out_valid_o(head_valid),
		.out_ready_i(fifo_pop)
	);

	// word handed across with a toggle; held until serial side takes it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			load_word <= '0;
			load_toggle <= 1'b0;
			waiting <= 1'b0;
			ack_1 <= 1'b0;
			ack_2 <= 1'b0;
		end
		else
		begin
			ack_1 <= load_taken;
			ack_2 <= ack_1;
			if (fifo_pop)
			begin
				load_word <= head_word;
				load_toggle <= !load_toggle;
				waiting <= 1'b1;
			end
			// serial side echoes the toggle once the word is in its shifter
			else if (ack_2 == load_toggle)
				waiting <= 1'b0;
		end
	end

	serial_port link (
		.sck_i(serial_shift_clock_i),
		.frame_n_i(conversion_start_input_i),
		.load_word_i(load_word),
		.load_toggle_i(load_toggle),
		.din_i(serial_config_input_i),
		.sdo_o(serial_result_output_o),
		.config_word_o(cfg_word),
		.config_toggle_o(cfg_toggle),
		.load_taken_o(load_taken)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_start;
		state == ST_ACQUIRE && start_rise;
	endsequence
	sequence s_open;
		!positive_sampling_switch_o && !negative_sampling_switch_o && !arrays_grounded_o;
	endsequence

	AST_START_OPENS: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start |=> state == ST_OPEN)
		else $error("start edge did not begin conversion");
	AST_OPEN_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start |=> s_open ##1 s_open ##1 arrays_grounded_o)
		else $error("arrays grounded before switches opened");
	AST_SIXTEEN: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_DONE |-> step == 5'h10 && weight == 16'h0000)
		else $error("wrong step count");
	AST_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_DONE |=> state == ST_ACQUIRE ##0 push_valid)
		else $error("no return to acquisition");
	AST_BOUNDED: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start |-> ##[1:900] state == ST_DONE)
		else $error("conversion did not finish");
	AST_OVER: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_DONE && over_seen |=> push_word[29:14] ==
		(unipolar ? sar_pkg::CODE_MAX_UNI : sar_pkg::CODE_MAX_BIP))
		else $error("overrange not saturated");
	AST_UNDER: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_DONE && under_seen && !over_seen |=> push_word[29:14] ==
		(unipolar ? sar_pkg::CODE_MIN_UNI : sar_pkg::CODE_MIN_BIP))
		else $error("underrange not saturated");
	AST_BIPOLAR: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_DONE && !unipolar && !over_seen && !under_seen
		|=> push_word[29:14] == {!sar[15], sar[14:0]})
		else $error("bipolar code wrong");
	AST_POWER: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_ACQUIRE && !start_rise |=> !converter_powered_o)
		else $error("converter powered while idle");
endmodule : sar_conversion_sequencer

// ---- sar_host_model.sv ----
// Purpose: host controller model for start, shift clock and config bits
// Assumes: shift clock idles low, 80 ns period, only inside frames
// Notes: config bits hold low outside the first fourteen clocks
`timescale 1ns/10ps
module sar_host_model (
	input wire logic clk_i,
	input wire logic result_bit_i,
	output logic start_o,
	output logic shift_clk_o,
	output logic cfg_bit_o
);
	initial
	begin
		start_o = 1'b0;
		shift_clk_o = 1'b0;
		cfg_bit_o = 1'b0;
	end
	// ----
	// start pulse, then held low so busy marks the end
	// ----
	task automatic start_pulse();
		start_o = 1'b1;
		repeat (4) @(negedge clk_i);
		start_o = 1'b0;
	endtask : start_pulse
	// ----
	// one 30-bit frame; offset keeps it out of phase with clk_i
	// ----
	task automatic xfer(input logic [13:0] cfg, output logic [29:0] got);
		#3;
		for (int i = 29; i >= 0; i--)
		begin
			cfg_bit_o = (i >= 16) ? cfg[i-16] : 1'b0;
			#40 shift_clk_o = 1'b1;
			got[i] = result_bit_i;
			#40 shift_clk_o = 1'b0;
		end
		cfg_bit_o = 1'b0;
	endtask : xfer
endmodule : sar_host_model

// ---- test_sar_conversion_sequencer.sv ----
// Purpose: self-checking bench for the conversion sequencer
// Assumes: comparator modelled as ideal against vin
// Notes: conversions spaced at least 200 clocks, the highest rate
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
		end \
	end
module test_sar_conversion_sequencer;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmp_high = 1'b0;
	logic over = 1'b0;
	logic under = 1'b0;
	logic start, shift_clk, cfg_bit, ser_out, sw_pos, sw_neg, grounded, powered, busy;
	logic [15:0] trial_code;
	logic [15:0] vin = 16'h0000;
	logic [13:0] cur_cfg = sar_pkg::CONFIG_RESET;
	logic [15:0] trials[$];
	logic [15:0] exp_q[$];
	logic [13:0] cfg_q[$];
	logic [15:0] fill[4] = '{16'h00FF, 16'hFF00, 16'hA5A5, 16'h5A5A};
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	always #5 clk_i = ~clk_i;
	sar_conversion_sequencer #(.BIT_CYC(5), .FIFO_DEPTH(4)) u_sar_conversion_sequencer (
		.clk_i(clk_i), .rst_i(rst_i), .conversion_start_input_i(start),
		.comparator_high_i(cmp_high), .over_range_i(over), .under_range_i(under),
		.serial_shift_clock_i(shift_clk), .serial_config_input_i(cfg_bit),
		.serial_result_output_o(ser_out), .positive_sampling_switch_o(sw_pos),
		.negative_sampling_switch_o(sw_neg), .arrays_grounded_o(grounded),
		.trial_code_o(trial_code), .converter_powered_o(powered), .busy_o(busy)
	);
	sar_host_model u_sar_host_model (
		.clk_i(clk_i), .result_bit_i(ser_out), .start_o(start),
		.shift_clk_o(shift_clk), .cfg_bit_o(cfg_bit)
	);
	// ----
	// ideal comparator and trial recorder
	// ----
	always @(negedge clk_i)
	begin
		cmp_high <= (vin >= trial_code);
		if (grounded === 1'b1 && (trials.size() == 0 || trials[$] !== trial_code))
			trials.push_back(trial_code);
	end
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 12000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// ----
	// one conversion, checked phase by phase
	// ----
	task automatic conv(input logic [15:0] v, input logic ovr, input logic und);
		int n;
		int p;
		int t0;
		logic [15:0] acc;
		logic [15:0] w;
		logic uni;
		@(negedge clk_i);
		vin = v;
		over = ovr;
		under = und;
		uni = cur_cfg[sar_pkg::UNIPOLAR_BIT];
		trials.delete();
		t0 = cyc;
		fork
			u_sar_host_model.start_pulse();
		join_none
		n = 0;
		while (sw_pos !== 1'b0 && n < 20)
		begin
			@(negedge clk_i);
			n++;
		end
		`CHK("grounded early", 1'b0, grounded);
		n = 0;
		while (grounded !== 1'b1 && n < 20)
		begin
			@(negedge clk_i);
			n++;
		end
		`CHK("grounded", 1'b1, grounded);
		`CHK("switches open", 2'b00, {sw_pos, sw_neg});
		`CHK("powered", 1'b1, powered);
		`CHK("busy", 1'b1, busy);
		n = 0;
		while (busy !== 1'b0 && n < 200)
		begin
			@(negedge clk_i);
			n++;
		end
		`CHK("end in time", 1'b1, n < 200);
		repeat (2) @(negedge clk_i);
		`CHK("acquire again", 2'b11, {sw_pos, sw_neg});
		`CHK("powered down", 1'b0, powered);
		acc = 16'h0000;
		p = 0;
		for (int k = 0; k < 16; k++)
		begin
			w = acc | (sar_pkg::MSB_WEIGHT >> k);
			while (p < trials.size() && trials[p] !== w)
				p++;
			`CHK("trial order", 1'b1, p < trials.size());
			if (v >= w)
				acc = w;
		end
		if (ovr)
			acc = uni ? sar_pkg::CODE_MAX_UNI : sar_pkg::CODE_MAX_BIP;
		else if (und)
			acc = uni ? sar_pkg::CODE_MIN_UNI : sar_pkg::CODE_MIN_BIP;
		else if (!uni)
			acc = v ^ 16'h8000;
		exp_q.push_back(acc);
		cfg_q.push_back(cur_cfg);
		while (cyc - t0 < 200)
			@(negedge clk_i);
	endtask : conv
	task automatic rd(input logic [13:0] cfg);
		logic [29:0] got;
		logic [15:0] e;
		logic [13:0] c;
		@(negedge clk_i);
		u_sar_host_model.xfer(cfg, got);
		e = exp_q.pop_front();
		c = cfg_q.pop_front();
		`CHK("result", e, got[29:14]);
		`CHK("config back", c, got[13:0]);
		cur_cfg = cfg;
	endtask : rd
	initial
	begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		`CHK("reset switches", 2'b11, {sw_pos, sw_neg});
		`CHK("reset idle", 3'b000, {busy, powered, grounded});
		conv(16'h1234, 1'b0, 1'b0);
		rd(14'h2C7F);
		conv(16'h1234, 1'b0, 1'b0);
		rd(14'h2C7F);
		conv(16'hFFFF, 1'b1, 1'b0);
		rd(14'h2C7F);
		conv(16'h0000, 1'b0, 1'b0);
		// previous result read and config written mid-conversion
		fork
			conv(16'hFFFF, 1'b0, 1'b0);
			begin
				repeat (10) @(negedge clk_i);
				rd(14'h3C7F);
			end
		join
		rd(14'h3C7F);
		conv(16'h0100, 1'b1, 1'b0);
		rd(14'h3C7F);
		conv(16'h0001, 1'b0, 1'b1);
		rd(14'h3C7F);
		// four results queued before any read, then drained in order
		foreach (fill[i])
			conv(fill[i], 1'b0, 1'b0);
		foreach (fill[i])
			rd(14'h3C7F);
		end_sim();
	end
endmodule : test_sar_conversion_sequencer
